// *** src/sbad_pkg.sv ***
// Constants and types of the system bus address decoder and arbiter.
package sbad_pkg;
  localparam int          NUM_MASTERS      = 4;
  localparam int          AREA_HI          = 31;
  localparam int          AREA_LO          = 28;
  localparam int          REGION_HI        = 27;
  localparam int          REGION_LO        = 20;
  localparam logic [3:0]  AREA_INTERNAL    = 4'h0;
  localparam logic [3:0]  AREA_EXT_FIRST   = 4'h1;
  localparam logic [3:0]  AREA_EXT_LAST    = 4'h8;
  localparam logic [3:0]  AREA_PERIPH      = 4'hF;
  localparam logic [7:0]  REGION_BOOT      = 8'h00;
  localparam logic [7:0]  REGION_ROM       = 8'h01;
  localparam logic [7:0]  REGION_SRAM      = 8'h02;
  localparam logic [7:0]  REGION_USB       = 8'h03;
  localparam logic [1:0]  SIZE_BYTE        = 2'h0;
  localparam logic [1:0]  SIZE_HALF        = 2'h1;
  localparam logic [1:0]  SIZE_WORD        = 2'h2;
  localparam logic [1:0]  ABORT_NONE       = 2'h0;
  localparam logic [1:0]  ABORT_UNMAPPED   = 2'h1;
  localparam logic [1:0]  ABORT_MISALIGNED = 2'h2;
  localparam logic [7:0]  EXT_CS_IDLE      = 8'hFF;
  localparam logic [2:0]  PRIO_LOWEST      = 3'h0;

  // Two edges fill the pin synchroniser before the third takes its level.
  typedef enum logic [1:0] {
    SBAD_BOOT_SYNC   = 2'b00,
    SBAD_BOOT_SETTLE = 2'b01,
    SBAD_BOOT_SAMPLE = 2'b11,
    SBAD_BOOT_RUN    = 2'b10
  } sbad_boot_e;

  typedef struct packed {
    logic        sync1;
    logic        sync2;
    sbad_boot_e  boot_phase;
    logic        boot_high;
    logic        remapped;
    logic [3:0]  grant;
    logic [7:0]  ext_cs_n;
    logic        rom_sel;
    logic        sram_sel;
    logic        usb_sel;
    logic        periph_sel;
    logic [31:0] addr;
    logic [1:0]  size;
    logic        write;
    logic [3:0]  abort;
    logic        abort_valid;
    logic [1:0]  abort_master;
    logic [1:0]  abort_type;
    logic [31:0] abort_addr;
    logic [1:0]  abort_size;
    logic        abort_write;
  } sbad_state_s;
endpackage

// *** src/sbad_decoder.sv ***
// System bus arbiter, address decoder, remap and abort capture.
////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Top four address bits pick one of sixteen 256-Mbyte areas.
// - Areas 1 to 8 assert external chip selects 0 to 7 in order.
// - Area 0 is internal memory, decoded further into 1-Mbyte regions.
// - Area 15 goes to the peripheral bus bridge.
// - Accesses to any other area or region are aborted.
// - SRAM answers at 0x200000, and also at zero after remap.
// - ROM always answers at 0x100000.
// - With boot pin high at reset, ROM answers at zero until remap.
// - Boot pin is sampled once at reset to choose the boot memory.
// - USB host registers answer as internal region at 0x300000.
// - Arbiter grants one of four masters, each with priority 0 to 7.
// - Misaligned data accesses are aborted.
// - Each abort records master, type, address, size and direction.
module sbad_decoder (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        boot_source_select_i,
  input  wire logic        remap_i,
  input  wire logic [3:0]  req_i,
  input  wire logic [3:0][31:0] m_addr_i,
  input  wire logic [3:0][1:0]  m_size_i,
  input  wire logic [3:0]  m_write_i,
  input  wire logic [3:0][2:0]  m_prio_i,
  output logic      [3:0]  grant_o,
  output logic      [7:0]  external_chip_select_n_o,
  output logic             rom_sel_o,
  output logic             sram_sel_o,
  output logic             usb_host_sel_o,
  output logic             periph_sel_o,
  output logic      [31:0] addr_o,
  output logic      [1:0]  size_o,
  output logic             write_o,
  output logic      [3:0]  abort_o,
  output logic             abort_valid_o,
  output logic      [1:0]  abort_master_o,
  output logic      [1:0]  abort_type_o,
  output logic      [31:0] abort_addr_o,
  output logic      [1:0]  abort_size_o,
  output logic             abort_write_o,
  output logic             boot_done_o
);

  localparam sbad_pkg::sbad_state_s RESET_STATE = '{
    ext_cs_n:   sbad_pkg::EXT_CS_IDLE,
    boot_phase: sbad_pkg::SBAD_BOOT_SYNC,
    default:    '0
  };

  sbad_pkg::sbad_state_s state;
  sbad_pkg::sbad_state_s next_state;

  logic        found;
  logic [1:0]  win;
  logic [2:0]  best;
  logic [31:0] a;
  logic [1:0]  sz;
  logic [3:0]  area;
  logic [7:0]  region;
  logic        misaligned;
  logic        mapped;
  logic [2:0]  cs_idx;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_state = state;
    found = 1'b0;
    win = 2'h0;
    best = sbad_pkg::PRIO_LOWEST;
    // The first stage feeds only the second, to keep metastability contained.
    next_state.sync1 = boot_source_select_i;
    next_state.sync2 = state.sync1;
    unique case (state.boot_phase)
      sbad_pkg::SBAD_BOOT_SYNC: begin
        next_state.boot_phase = sbad_pkg::SBAD_BOOT_SETTLE;
      end
      sbad_pkg::SBAD_BOOT_SETTLE: begin
        next_state.boot_phase = sbad_pkg::SBAD_BOOT_SAMPLE;
      end
      sbad_pkg::SBAD_BOOT_SAMPLE: begin
        next_state.boot_high = state.sync2;
        next_state.boot_phase = sbad_pkg::SBAD_BOOT_RUN;
      end
      sbad_pkg::SBAD_BOOT_RUN: begin
      end
    endcase
    if (remap_i) begin
      next_state.remapped = 1'b1;
    end
    next_state.grant = '0;
    next_state.abort = '0;
    next_state.ext_cs_n = sbad_pkg::EXT_CS_IDLE;
    next_state.rom_sel = 1'b0;
    next_state.sram_sel = 1'b0;
    next_state.usb_sel = 1'b0;
    next_state.periph_sel = 1'b0;
    // Strict comparison keeps the lower index on a tie.
    for (int i = 0; i < sbad_pkg::NUM_MASTERS; i++) begin
      if (req_i[i] && (!found || m_prio_i[i] > best)) begin
        found = 1'b1;
        win = 2'(i);
        best = m_prio_i[i];
      end
    end
    a = m_addr_i[win];
    sz = m_size_i[win];
    area = a[sbad_pkg::AREA_HI:sbad_pkg::AREA_LO];
    region = a[sbad_pkg::REGION_HI:sbad_pkg::REGION_LO];
    cs_idx = 3'(area - sbad_pkg::AREA_EXT_FIRST);
    misaligned = (sz == sbad_pkg::SIZE_HALF && a[0]) ||
                 (sz == sbad_pkg::SIZE_WORD && a[1:0] != 2'h0) ||
                 (sz != sbad_pkg::SIZE_BYTE && sz != sbad_pkg::SIZE_HALF &&
                  sz != sbad_pkg::SIZE_WORD);
    mapped = 1'b1;
    if (found && state.boot_phase == sbad_pkg::SBAD_BOOT_RUN) begin
      if (area >= sbad_pkg::AREA_EXT_FIRST &&
          area <= sbad_pkg::AREA_EXT_LAST) begin
        next_state.ext_cs_n[cs_idx] = 1'b0;
      end else if (area == sbad_pkg::AREA_PERIPH) begin
        next_state.periph_sel = 1'b1;
      end else if (area == sbad_pkg::AREA_INTERNAL) begin
        if (region == sbad_pkg::REGION_BOOT) begin
          if (state.remapped) begin
            next_state.sram_sel = 1'b1;
          end else if (state.boot_high) begin
            next_state.rom_sel = 1'b1;
          end else begin
            next_state.ext_cs_n[0] = 1'b0;
          end
        end else if (region == sbad_pkg::REGION_ROM) begin
          next_state.rom_sel = 1'b1;
        end else if (region == sbad_pkg::REGION_SRAM) begin
          next_state.sram_sel = 1'b1;
        end else if (region == sbad_pkg::REGION_USB) begin
          next_state.usb_sel = 1'b1;
        end else begin
          mapped = 1'b0;
        end
      end else begin
        mapped = 1'b0;
      end
      if (!mapped || misaligned) begin
        // A failed access selects nothing, so no slave sees it.
        next_state.ext_cs_n = sbad_pkg::EXT_CS_IDLE;
        next_state.rom_sel = 1'b0;
        next_state.sram_sel = 1'b0;
        next_state.usb_sel = 1'b0;
        next_state.periph_sel = 1'b0;
        next_state.abort[win] = 1'b1;
        next_state.abort_valid = 1'b1;
        next_state.abort_master = win;
        next_state.abort_type = !mapped ? sbad_pkg::ABORT_UNMAPPED
                                        : sbad_pkg::ABORT_MISALIGNED;
        next_state.abort_addr = a;
        next_state.abort_size = sz;
        next_state.abort_write = m_write_i[win];
      end else begin
        next_state.grant[win] = 1'b1;
        next_state.addr = a;
        next_state.size = sz;
        next_state.write = m_write_i[win];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= RESET_STATE;
    end else begin
      state <= next_state;
    end
  end

  assign grant_o = state.grant;
  assign external_chip_select_n_o = state.ext_cs_n;
  assign rom_sel_o = state.rom_sel;
  assign sram_sel_o = state.sram_sel;
  assign usb_host_sel_o = state.usb_sel;
  assign periph_sel_o = state.periph_sel;
  assign addr_o = state.addr;
  assign size_o = state.size;
  assign write_o = state.write;
  assign abort_o = state.abort;
  assign abort_valid_o = state.abort_valid;
  assign abort_master_o = state.abort_master;
  assign abort_type_o = state.abort_type;
  assign abort_addr_o = state.abort_addr;
  assign abort_size_o = state.abort_size;
  assign abort_write_o = state.abort_write;
  assign boot_done_o = (state.boot_phase == sbad_pkg::SBAD_BOOT_RUN);

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  logic [3:0] out_area;
  logic [7:0] out_region;
  assign out_area = addr_o[sbad_pkg::AREA_HI:sbad_pkg::AREA_LO];
  assign out_region = addr_o[sbad_pkg::REGION_HI:sbad_pkg::REGION_LO];

  sequence s_boot_access;
    (|grant_o) && out_area == sbad_pkg::AREA_INTERNAL &&
    out_region == sbad_pkg::REGION_BOOT;
  endsequence

  sequence s_settled;
    boot_done_o ##1 boot_done_o;
  endsequence

  AST_GRANT_ONEHOT: assert property ($onehot0(grant_o | abort_o))
    else $error("More than one master answered in a cycle.");

  for (genvar i = 0; i < sbad_pkg::NUM_MASTERS; i++) begin : g_pri
    for (genvar j = 0; j < sbad_pkg::NUM_MASTERS; j++) begin : g_cmp
      AST_PRIO_ORDER: assert property (
        (req_i[j] && (m_prio_i[j] > m_prio_i[i] ||
         (m_prio_i[j] == m_prio_i[i] && j < i)))
        |=> !grant_o[i] && !abort_o[i])
        else $error("A lower ranked master won arbitration.");
    end
  end

  AST_EXT_AREA: assert property (
    ((|grant_o) && out_area >= sbad_pkg::AREA_EXT_FIRST &&
     out_area <= sbad_pkg::AREA_EXT_LAST) |->
    external_chip_select_n_o ==
      ~(8'h01 << 3'(out_area - sbad_pkg::AREA_EXT_FIRST)))
    else $error("Wrong external chip select for the area.");

  AST_PERIPH_AREA: assert property (
    periph_sel_o |-> (|grant_o) && out_area == sbad_pkg::AREA_PERIPH)
    else $error("Peripheral select outside the peripheral area.");

  AST_ROM_FIXED: assert property (
    ((|grant_o) && out_area == sbad_pkg::AREA_INTERNAL &&
     out_region == sbad_pkg::REGION_ROM) |-> rom_sel_o)
    else $error("ROM not selected at its fixed base.");

  AST_BOOT_MAP: assert property (
    s_boot_access |-> ($past(state.remapped) ? sram_sel_o :
      ($past(state.boot_high) ? rom_sel_o
                              : !external_chip_select_n_o[0])))
    else $error("Address zero reached the wrong memory.");

  AST_ALIGNED_ONLY: assert property (
    (|grant_o) |-> (size_o == sbad_pkg::SIZE_BYTE) ||
      (size_o == sbad_pkg::SIZE_HALF && !addr_o[0]) ||
      (size_o == sbad_pkg::SIZE_WORD && addr_o[1:0] == 2'h0))
    else $error("A misaligned access was granted.");

  AST_MAPPED_ONLY: assert property (
    (|grant_o) |->
      (out_area == sbad_pkg::AREA_INTERNAL &&
       out_region <= sbad_pkg::REGION_USB) ||
      (out_area >= sbad_pkg::AREA_EXT_FIRST &&
       out_area <= sbad_pkg::AREA_EXT_LAST) ||
      out_area == sbad_pkg::AREA_PERIPH)
    else $error("An access to an unused area was granted.");

  AST_ABORT_RECORD: assert property (
    (|abort_o) |-> abort_valid_o && abort_o[abort_master_o] &&
      abort_type_o != sbad_pkg::ABORT_NONE)
    else $error("Abort status does not match the aborted master.");

  AST_BOOT_STABLE: assert property (
    s_settled |-> $stable(state.boot_high))
    else $error("Boot selection changed after it was sampled.");

endmodule

// *** bench/sbad_masters.sv ***
// Model of the four bus masters that face the decoder.
module sbad_masters (
  input  wire logic             clk_i,
  input  wire logic [3:0]       grant_i,
  input  wire logic [3:0]       abort_i,
  output logic      [3:0]       req_o,
  output logic      [3:0][31:0] addr_o,
  output logic      [3:0][1:0]  size_o,
  output logic      [3:0]       write_o,
  output logic      [3:0][2:0]  prio_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    req_o   = '0;
    addr_o  = '0;
    size_o  = '0;
    write_o = '0;
    prio_o  = '0;
  end
  ////////////////////////////////////////////////////////////////////////
  // A master holds its request until answered, then lets go.
  // Released address lines flip so a stale value never looks held.
  always @(negedge clk_i) begin
    for (int m = 0; m < 4; m++) begin
      if (req_o[m] && (grant_i[m] || abort_i[m])) begin
        req_o[m]  <= 1'b0;
        addr_o[m] <= ~addr_o[m];
      end
    end
  end
  // Called just after a falling edge.
  task automatic issue(input int m, input logic [31:0] a,
                       input logic [1:0] s, input logic w,
                       input logic [2:0] p);
    req_o[m]   <= 1'b1;
    addr_o[m]  <= a;
    size_o[m]  <= s;
    write_o[m] <= w;
    prio_o[m]  <= p;
  endtask
endmodule

// *** bench/testbench.sv ***
// Self-checking bench of the system bus decoder and arbiter.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic             clk, rst_n, boot_pin, remap;
  logic [3:0]       req, m_write, grant, abort;
  logic [3:0][31:0] m_addr;
  logic [3:0][1:0]  m_size;
  logic [3:0][2:0]  m_prio;
  logic [7:0]       cs_n;
  logic             rom, sram, usb, per, wr, a_valid, a_write, boot_done;
  logic [31:0]      addr, a_addr;
  logic [1:0]       size, a_master, a_type, a_size;
  int               n_fail, comparisons, cycles;
  ////////////////////////////////////////////////////////////////////////
  sbad_masters i_masters (.clk_i(clk), .grant_i(grant), .abort_i(abort),
    .req_o(req), .addr_o(m_addr), .size_o(m_size), .write_o(m_write),
    .prio_o(m_prio));
  sbad_decoder i_dut (.clk_i(clk), .rst_n_i(rst_n),
    .boot_source_select_i(boot_pin), .remap_i(remap), .req_i(req),
    .m_addr_i(m_addr), .m_size_i(m_size), .m_write_i(m_write),
    .m_prio_i(m_prio), .grant_o(grant), .external_chip_select_n_o(cs_n),
    .rom_sel_o(rom), .sram_sel_o(sram), .usb_host_sel_o(usb),
    .periph_sel_o(per), .addr_o(addr), .size_o(size), .write_o(wr),
    .abort_o(abort), .abort_valid_o(a_valid), .abort_master_o(a_master),
    .abort_type_o(a_type), .abort_addr_o(a_addr), .abort_size_o(a_size),
    .abort_write_o(a_write), .boot_done_o(boot_done));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // The whole run needs well under a thousand cycles.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic do_reset(input logic pin);
    @(negedge clk);
    rst_n = 1'b0;
    boot_pin = pin;
    remap = 1'b0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    for (int i = 0; i < 8 && boot_done !== 1'b1; i++) @(negedge clk);
    chk("boot_done", 32'h1, boot_done);
    chk("abort_valid", 32'h0, a_valid);
  endtask
  task automatic do_remap();
    @(negedge clk);
    remap = 1'b1;
    @(negedge clk);
    remap = 1'b0;
  endtask
  // One access; its answer is judged on the falling edge after it is taken.
  task automatic acc(input int m, input logic [31:0] a, input logic [1:0] s,
                     input logic [7:0] e_cs, input logic [3:0] e_sel,
                     input logic [1:0] e_abt);
    @(negedge clk);
    i_masters.issue(m, a, s, m[0], 3'h0);
    @(negedge clk);
    chk("grant", e_abt == 2'h0 ? 4'h1 << m : 4'h0, grant);
    chk("abort", e_abt != 2'h0 ? 4'h1 << m : 4'h0, abort);
    chk("cs_n", e_cs, cs_n);
    chk("selects", e_sel, {rom, sram, usb, per});
    if (e_abt != 2'h0) begin
      chk("abort_valid", 32'h1, a_valid);
      chk("abort_type", e_abt, a_type);
      chk("abort_master", m, a_master);
      chk("abort_addr", a, a_addr);
      chk("abort_size_dir", {s, m[0]}, {a_size, a_write});
    end else begin
      chk("addr", a, addr);
      chk("size_dir", {s, m[0]}, {size, wr});
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_map();
    logic [7:0] cs_exp;
    do_reset(1'b0);
    acc(0, 32'h0000_0000, 2'h2, 8'hFE, 4'h0, 2'h0);
    for (int k = 1; k <= 8; k++) begin
      cs_exp = ~(8'h01 << (k - 1));
      acc(k % 4, {k[3:0], 28'h000_0104}, 2'h2, cs_exp, 4'h0, 2'h0);
    end
    acc(1, 32'hFFFA_0010, 2'h2, 8'hFF, 4'h1, 2'h0);
    acc(2, 32'h0010_0004, 2'h2, 8'hFF, 4'h8, 2'h0);
    acc(3, 32'h0020_0008, 2'h2, 8'hFF, 4'h4, 2'h0);
    acc(0, 32'h0030_0010, 2'h2, 8'hFF, 4'h2, 2'h0);
    for (int k = 9; k <= 14; k++) begin
      acc(k % 4, {k[3:0], 28'h000_0000}, 2'h1, 8'hFF, 4'h0, 2'h1);
    end
    acc(1, 32'h0040_0000, 2'h2, 8'hFF, 4'h0, 2'h1);
    $display("test map done");
  endtask
  task automatic t_misalign();
    acc(0, 32'h0010_0002, 2'h2, 8'hFF, 4'h0, 2'h2);
    acc(1, 32'h0020_0001, 2'h1, 8'hFF, 4'h0, 2'h2);
    acc(2, 32'h0020_0003, 2'h0, 8'hFF, 4'h4, 2'h0);
    acc(3, 32'h0020_0000, 2'h3, 8'hFF, 4'h0, 2'h2);
    acc(0, 32'h9000_0002, 2'h2, 8'hFF, 4'h0, 2'h1);
    $display("test misalign done");
  endtask
  task automatic t_remap();
    do_remap();
    acc(0, 32'h0000_0010, 2'h2, 8'hFF, 4'h4, 2'h0);
    acc(1, 32'h0010_0000, 2'h2, 8'hFF, 4'h8, 2'h0);
    do_reset(1'b1);
    acc(2, 32'h0000_0000, 2'h2, 8'hFF, 4'h8, 2'h0);
    acc(3, 32'h0020_0000, 2'h2, 8'hFF, 4'h4, 2'h0);
    do_remap();
    acc(0, 32'h0000_0004, 2'h2, 8'hFF, 4'h4, 2'h0);
    $display("test remap done");
  endtask
  task automatic t_arb();
    @(negedge clk);
    i_masters.issue(0, 32'h0010_0000, 2'h2, 1'b0, 3'h2);
    i_masters.issue(3, 32'h0020_0000, 2'h2, 1'b1, 3'h5);
    i_masters.issue(1, 32'hF000_0000, 2'h2, 1'b0, 3'h5);
    @(negedge clk);
    chk("grant", 32'h2, grant);
    @(negedge clk);
    chk("grant", 32'h8, grant);
    chk("addr", 32'h0020_0000, addr);
    @(negedge clk);
    chk("grant", 32'h1, grant);
    i_masters.issue(2, 32'h0010_0000, 2'h2, 1'b0, 3'h0);
    i_masters.issue(3, 32'h1000_0000, 2'h2, 1'b0, 3'h7);
    @(negedge clk);
    chk("grant", 32'h8, grant);
    @(negedge clk);
    chk("grant", 32'h4, grant);
    $display("test arbitration done");
  endtask
  initial begin
    rst_n = 1'b0;
    boot_pin = 1'b0;
    remap = 1'b0;
    t_map();
    t_misalign();
    t_remap();
    t_arb();
    end_sim();
  end
endmodule
